// *** src/fault_thr_pkg.sv ***
// Purpose: shared constants and types for the output fault threshold register bank
// Assumes: byte-wide register port, 100 MHz clock, millivolt/degree telemetry codes
// Notes: voltage thresholds are millivolt offsets applied to the commanded output target
`default_nettype none
package fault_thr_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OV_ACTION = 8'h41;
    localparam logic [7:0] OFS_OV_WARN = 8'h42;
    localparam logic [7:0] OFS_UV_WARN = 8'h43;
    localparam logic [7:0] OFS_UV_FAULT = 8'h44;
    localparam logic [7:0] OFS_UV_ACTION = 8'h45;
    localparam logic [7:0] OFS_OC_LIMIT = 8'h46;
    localparam logic [7:0] OFS_OT_FAULT = 8'h4F;
    // ----------------------------------------------------------------
    // field positions and writable masks
    // ----------------------------------------------------------------
    localparam int RESTART_BIT = 3;
    localparam logic [7:0] MASK_ACTION_OV = 8'h08;
    localparam logic [7:0] MASK_ACTION_UV = 8'h0B;
    localparam logic [7:0] MASK_SEL2 = 8'h03;
    localparam logic [7:0] MASK_SEL3 = 8'h07;
    localparam logic [7:0] MASK_SEL4 = 8'h0F;
    // ----------------------------------------------------------------
    // threshold tables, millivolts and degrees
    // ----------------------------------------------------------------
    localparam logic [11:0] MV_100 = 12'h064;
    localparam logic [11:0] MV_150 = 12'h096;
    localparam logic [11:0] MV_200 = 12'h0C8;
    localparam logic [11:0] MV_300 = 12'h12C;
    localparam logic [7:0] OT_BASE_C = 8'h73;
    localparam logic [7:0] OT_STEP_C = 8'h05;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 10;
    localparam int DLY0_US = 2;
    localparam int DLY1_US = 16;
    localparam int DLY2_US = 64;
    localparam int DLY3_US = 256;
    localparam int RESTART_MS = 56;
    localparam int OV_DETECT_NS = 1000;
    localparam int DLY0_CYC = DLY0_US * CLK_MHZ;
    localparam int DLY1_CYC = DLY1_US * CLK_MHZ;
    localparam int DLY2_CYC = DLY2_US * CLK_MHZ;
    localparam int DLY3_CYC = DLY3_US * CLK_MHZ;
    localparam int RESTART_CYC_DEF = RESTART_MS * 1000 * CLK_MHZ;
    localparam int OV_DETECT_CYC = OV_DETECT_NS / CLK_NS;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic overvolt_fault_flag;
        logic undervolt_fault_flag;
        logic overvolt_warning_flag;
        logic undervolt_warning_flag;
    } vout_status_t;
    typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_RESTART} prot_state_t;
endpackage
`default_nettype wire

// *** src/output_fault_threshold_regs.sv ***
// Purpose: fault threshold registers and output protection response
// Assumes: sensed output and target in mV, temperature in degrees C, valley
//          current as a 4-bit code, all from other clock domains of the die
// Notes: registers load nvm values while i_nvm_load is high
// Operation
// - overvoltage restart bit: latch or 56ms retry
// - overvoltage warning offsets 100/150/200/300 mV above
// - set overvoltage warning when output exceeds threshold
// - undervoltage warning offsets 100/150/200/300 mV below
// - set undervoltage warning when output below threshold
// - undervoltage fault offsets 150/200/200/300 mV below
// - undervoltage fault detection only after soft-start
// - undervoltage fault sets flag, starts delay timer
// - recovery during delay clears timer to zero
// - delay field selects 2/16/64/256 us
// - undervoltage restart bit: latch or 56ms retry
// - reserved bits read zero, not writable
// - valley current compared to 4-bit limit
// - temperature fault 115 to 150 C, 5C steps
// - thresholds track present output target
// - overvoltage fault sets flag, enters negative current mode
// - overvoltage fault detection only after soft-start
`default_nettype none
module output_fault_threshold_regs
    import fault_thr_pkg::*;
#(
    parameter int RESTART_CYC = RESTART_CYC_DEF
)(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    input wire logic i_nvm_load,
    input wire logic [7:0] i_nvm_ov_action,
    input wire logic [7:0] i_nvm_ov_warn,
    input wire logic [7:0] i_nvm_uv_warn,
    input wire logic [7:0] i_nvm_uv_fault,
    input wire logic [7:0] i_nvm_uv_action,
    input wire logic [7:0] i_nvm_oc_limit,
    input wire logic [7:0] i_nvm_ot_fault,
    input wire logic [12:0] i_vout_target_mv,
    input wire logic [12:0] i_output_sense_mv,
    input wire logic [11:0] i_ov_fault_offset_mv,
    input wire logic i_soft_start_done,
    input wire logic [3:0] i_valley_current_code,
    input wire logic [7:0] i_die_temp_c,
    input wire logic i_status_clear,
    input wire logic i_enable_toggle,
    output vout_status_t o_status,
    output logic o_negative_current_limit_mode,
    output logic o_converter_off,
    output logic o_overcurrent_fault,
    output logic o_overtemp_fault
);
    // ----------------------------------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rstn;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rstn = rst_sync_q[1];

    localparam int SW = 13 + 13 + 12 + 1 + 4 + 8 + 1;
    logic [SW-1:0] s1_q, s2_q, s3_q, word_q;
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            word_q <= '0;
        end
        else
        begin
            s1_q <= {i_vout_target_mv, i_output_sense_mv, i_ov_fault_offset_mv,
                     i_soft_start_done, i_valley_current_code, i_die_temp_c,
                     i_enable_toggle};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a multi-bit word is taken only once two samples agree, so a value caught
            // mid-change never reaches the comparators; telemetry that never holds
            // still for two cycles is never taken, which the slow sensors allow
            if (s3_q == s2_q) word_q <= s3_q;
        end
    end
    logic [12:0] target_mv, sense_mv;
    logic [11:0] ovf_ofs;
    logic ss_done, en_tog;
    logic [3:0] valley;
    logic [7:0] temp_c;
    assign {target_mv, sense_mv, ovf_ofs, ss_done, valley, temp_c, en_tog} = word_q;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    localparam int NREG = 7;
    localparam logic [7:0] OFS [NREG] = '{OFS_OV_ACTION, OFS_OV_WARN, OFS_UV_WARN,
        OFS_UV_FAULT, OFS_UV_ACTION, OFS_OC_LIMIT, OFS_OT_FAULT};
    localparam logic [7:0] MSK [NREG] = '{MASK_ACTION_OV, MASK_SEL2, MASK_SEL2,
        MASK_SEL2, MASK_ACTION_UV, MASK_SEL4, MASK_SEL3};
    logic [7:0] regs_q [NREG];
    logic [7:0] nvm [NREG];
    logic [NREG-1:0] hit;
    assign nvm = '{i_nvm_ov_action, i_nvm_ov_warn, i_nvm_uv_warn, i_nvm_uv_fault,
        i_nvm_uv_action, i_nvm_oc_limit, i_nvm_ot_fault};

    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_reg
            assign hit[g] = (i_req.addr == OFS[g]);
            always_ff @(posedge i_clk or negedge rstn)
            begin
                if (!rstn) regs_q[g] <= 8'h00;
                else if (i_nvm_load) regs_q[g] <= nvm[g] & MSK[g];
                else if (i_req.wr && hit[g]) regs_q[g] <= i_req.wdata & MSK[g];
            end
        end
    endgenerate

    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        for (int i = 0; i < NREG; i++)
            if (hit[i]) rd_mux = regs_q[i];
    end
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn) o_rdata <= 8'h00;
        else if (i_req.rd) o_rdata <= rd_mux;
    end

    wire ov_restart = regs_q[0][RESTART_BIT];
    wire [1:0] ovw_sel = regs_q[1][1:0];
    wire [1:0] uvw_sel = regs_q[2][1:0];
    wire [1:0] uvf_sel = regs_q[3][1:0];
    wire uv_restart = regs_q[4][RESTART_BIT];
    wire [1:0] dly_sel = regs_q[4][1:0];
    wire [3:0] valley_limit_select = regs_q[5][3:0];
    wire [2:0] overtemp_fault_select = regs_q[6][2:0];

    // ----------------------------------------------------------------
    // threshold decode
    // ----------------------------------------------------------------
    function automatic logic [11:0] warn_mv(input logic [1:0] sel);
        case (sel)
            2'b00: warn_mv = MV_100;
            2'b01: warn_mv = MV_150;
            2'b10: warn_mv = MV_200;
            default: warn_mv = MV_300;
        endcase
    endfunction
    function automatic logic [11:0] uvf_mv(input logic [1:0] sel);
        case (sel)
            2'b00: uvf_mv = MV_150;
            2'b11: uvf_mv = MV_300;
            default: uvf_mv = MV_200;
        endcase
    endfunction

    // thresholds follow whatever target is live now, no latching of it
    wire [13:0] ovw_thr = {1'b0, target_mv} + {2'b00, warn_mv(ovw_sel)};
    wire [13:0] ovf_thr = {1'b0, target_mv} + {2'b00, ovf_ofs};
    wire [13:0] uvw_thr = {1'b0, target_mv} - {2'b00, warn_mv(uvw_sel)};
    wire [13:0] uvf_thr = {1'b0, target_mv} - {2'b00, uvf_mv(uvf_sel)};
    wire [14:0] sns = {2'b00, sense_mv};
    // a negative difference means threshold below zero: never under it
    wire ovw_hit = sns > {1'b0, ovw_thr};
    wire ovf_hit = (sns > {1'b0, ovf_thr}) && ss_done;
    wire uvw_hit = !uvw_thr[13] && (sns < {1'b0, uvw_thr});
    wire uvf_hit = !uvf_thr[13] && (sns < {1'b0, uvf_thr}) && ss_done;

    wire [7:0] ot_thr = 8'(OT_BASE_C + OT_STEP_C * overtemp_fault_select);
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            o_overcurrent_fault <= 1'b0;
            o_overtemp_fault <= 1'b0;
        end
        else
        begin
            o_overcurrent_fault <= valley > valley_limit_select;
            o_overtemp_fault <= temp_c >= ot_thr;
        end
    end

    // ----------------------------------------------------------------
    // undervoltage qualification timer
    // ----------------------------------------------------------------
    logic [15:0] uv_tmr_q;
    logic [15:0] dly_cyc;
    always_comb
    begin
        case (dly_sel)
            2'b00: dly_cyc = 16'(DLY0_CYC);
            2'b01: dly_cyc = 16'(DLY1_CYC);
            2'b10: dly_cyc = 16'(DLY2_CYC);
            default: dly_cyc = 16'(DLY3_CYC);
        endcase
    end
    wire uv_qualified = uvf_hit && (uv_tmr_q >= dly_cyc - 16'h0001);
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn) uv_tmr_q <= 16'h0000;
        else if (!uvf_hit) uv_tmr_q <= 16'h0000;
        else if (!uv_qualified) uv_tmr_q <= uv_tmr_q + 16'h0001;
    end

    // ----------------------------------------------------------------
    // status flags, sticky; a new event wins over a clear
    // ----------------------------------------------------------------
    vout_status_t ev, st_q;
    assign ev = {ovf_hit, uvf_hit, ovw_hit, uvw_hit};
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn) st_q <= '0;
        else if (i_status_clear) st_q <= ev;
        else st_q <= st_q | ev;
    end
    assign o_status = st_q;

    // ----------------------------------------------------------------
    // fault response
    // ----------------------------------------------------------------
    prot_state_t state_q, state_d;
    logic [31:0] rs_cnt_q;
    logic noc_q;
    logic en_tog_q;
    wire en_edge = en_tog ^ en_tog_q;
    wire rs_done = rs_cnt_q >= 32'(RESTART_CYC - 1);
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (ovf_hit)
                    state_d = ov_restart ? ST_RESTART : ST_LATCHED;
                else if (uv_qualified)
                    state_d = uv_restart ? ST_RESTART : ST_LATCHED;
            ST_LATCHED:
                if (en_edge) state_d = ST_RUN;
            ST_RESTART:
                if (rs_done) state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_RUN;
            rs_cnt_q <= 32'h00000000;
            noc_q <= 1'b0;
            en_tog_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            en_tog_q <= en_tog;
            rs_cnt_q <= (state_q == ST_RESTART) ? rs_cnt_q + 32'h00000001 : 32'h00000000;
            noc_q <= ovf_hit || (noc_q && state_d != ST_RUN);
        end
    end
    assign o_converter_off = (state_q != ST_RUN);
    assign o_negative_current_limit_mode = noc_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_ovf_noc: assert property (@(posedge i_clk) disable iff (!rstn)
        ovf_hit |=> noc_q && st_q.overvolt_fault_flag)
        else $error("overvoltage fault did not enter negative current mode");
    chk_ss_gate_uv: assert property (@(posedge i_clk) disable iff (!rstn)
        !ss_done && !st_q.undervolt_fault_flag && !noc_q
        |=> !st_q.undervolt_fault_flag && !noc_q)
        else $error("fault detection active before soft-start done");
    chk_uv_tmr_clear: assert property (@(posedge i_clk) disable iff (!rstn)
        !uvf_hit |=> uv_tmr_q == 16'h0000)
        else $error("undervoltage timer not cleared on recovery");
    chk_uv_delay_min: assert property (@(posedge i_clk) disable iff (!rstn)
        $rose(uvf_hit) && dly_sel == 2'b00 |-> !uv_qualified [*8])
        else $error("undervoltage qualified too early");
    // helper: consecutive running cycles below the fault level at the 2 us code
    logic [7:0] uv_run_q;
    wire uv_run = uvf_hit && dly_sel == 2'b00 && !o_converter_off;
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn) uv_run_q <= 8'h00;
        else if (!uv_run) uv_run_q <= 8'h00;
        else if (uv_run_q != 8'hFF) uv_run_q <= uv_run_q + 8'h01;
    end
    chk_uv_delay_2us: assert property (@(posedge i_clk) disable iff (!rstn)
        uv_run && uv_run_q >= 8'(DLY0_CYC - 1) |-> uv_qualified)
        else $error("2 us undervoltage delay not honoured");
    chk_latch_hold: assert property (@(posedge i_clk) disable iff (!rstn)
        state_q == ST_LATCHED && !en_edge |=> state_q == ST_LATCHED)
        else $error("latched fault released without enable toggle");
    chk_uv_latch: assert property (@(posedge i_clk) disable iff (!rstn)
        state_q == ST_RUN && !ovf_hit && uv_qualified && !uv_restart |=> state_q == ST_LATCHED)
        else $error("undervoltage latch-off not taken");
    chk_warn_sticky: assert property (@(posedge i_clk) disable iff (!rstn)
        st_q.overvolt_warning_flag && !i_status_clear |=> st_q.overvolt_warning_flag)
        else $error("overvoltage warning lost without clear");
    chk_resv_zero: assert property (@(posedge i_clk) disable iff (!rstn)
        $past(i_req.rd) && $past(i_req.addr) == OFS_OC_LIMIT |-> o_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    cov_ov_restart: cover property (@(posedge i_clk) disable iff (!rstn)
        state_q == ST_RESTART ##1 state_q == ST_RUN);
    cov_uv_qual: cover property (@(posedge i_clk) disable iff (!rstn) uv_qualified);
    cov_uv_recover: cover property (@(posedge i_clk) disable iff (!rstn)
        uvf_hit ##1 !uvf_hit ##1 uvf_hit);
    cov_latched: cover property (@(posedge i_clk) disable iff (!rstn) state_q == ST_LATCHED);
endmodule
`default_nettype wire

// *** test/reg_host_model.sv ***
// Purpose: host side of the byte-wide register port of the threshold bank
// Assumes: one request at a time, rd and wr one-cycle pulses on the rising edge
// Notes: the host cannot learn of faults, no register maps status and there is no alert line
`default_nettype none
module reg_host_model
    import fault_thr_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output var reg_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_req = '0;
    // ----------------------------------------------------------------
    // byte write and byte read, released only after the taking edge
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        o_req <= '0;
    endtask
    // polling read of one mapped register; status is not among them
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        o_req <= '0;
        #1 d = i_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/output_fault_threshold_regs_bench.sv ***
// Purpose: self-checking bench for the output fault threshold register bank
// Assumes: restart wait shortened to 50 cycles, target 1000 mV and up
// Notes: expected values come from the package tables, never from the dut
`default_nettype none
module output_fault_threshold_regs_bench
    import fault_thr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RCYC = 50;
    localparam logic [7:0] OFS [7] = '{OFS_OV_ACTION, OFS_OV_WARN, OFS_UV_WARN, OFS_UV_FAULT,
        OFS_UV_ACTION, OFS_OC_LIMIT, OFS_OT_FAULT};
    localparam logic [7:0] MSK [7] = '{MASK_ACTION_OV, MASK_SEL2, MASK_SEL2, MASK_SEL2,
        MASK_ACTION_UV, MASK_SEL4, MASK_SEL3};
    localparam logic [11:0] WMV [4] = '{MV_100, MV_150, MV_200, MV_300};
    localparam logic [11:0] FMV [4] = '{MV_150, MV_200, MV_200, MV_300};
    localparam int DLY [4] = '{DLY0_CYC, DLY1_CYC, DLY2_CYC, DLY3_CYC};
    logic clk = 1'b0, rstn = 1'b0, nvm_load = 1'b0, ss_done = 1'b0;
    logic st_clr = 1'b0, en_tog = 1'b0, negative_current_limit_mode, off, ocf, otf;
    logic [7:0] nvm [7];
    logic [12:0] tgt = 13'h03E8, sns = 13'h03E8;
    logic [3:0] valley = 4'h0;
    logic [7:0] temp = 8'h00, rdata, d;
    reg_req_t req;
    vout_status_t st;
    int err_count = 0, comparisons = 0;
    always #5 clk = ~clk;
    reg_host_model host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    output_fault_threshold_regs #(.RESTART_CYC(RCYC)) dut (
        .i_clk(clk), .i_rstn(rstn), .i_req(req), .o_rdata(rdata), .i_nvm_load(nvm_load),
        .i_nvm_ov_action(nvm[0]), .i_nvm_ov_warn(nvm[1]), .i_nvm_uv_warn(nvm[2]),
        .i_nvm_uv_fault(nvm[3]), .i_nvm_uv_action(nvm[4]), .i_nvm_oc_limit(nvm[5]),
        .i_nvm_ot_fault(nvm[6]), .i_vout_target_mv(tgt), .i_output_sense_mv(sns),
        .i_ov_fault_offset_mv(12'h190), .i_soft_start_done(ss_done),
        .i_valley_current_code(valley), .i_die_temp_c(temp), .i_status_clear(st_clr),
        .i_enable_toggle(en_tog), .o_status(st), .o_negative_current_limit_mode(negative_current_limit_mode),
        .o_converter_off(off), .o_overcurrent_fault(ocf), .o_overtemp_fault(otf));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // sense settles through the sync and word-capture stages before anything is judged
    task automatic drive(input int t, input int s, input int n);
        @(posedge clk);
        tgt <= 13'(t);
        sns <= 13'(s);
        step(n);
    endtask
    // clear is refused while an event stands, so sense goes home first
    task automatic clr_status();
        drive(tgt, tgt, 6);
        st_clr <= 1'b1;
        step(1);
        st_clr <= 1'b0;
        step(2);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_regs();
        nvm_load <= 1'b1;
        step(2);
        nvm_load <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            host.rd(OFS[i], d);
            chk(d, nvm[i] & MSK[i], "power-up value");
            host.wr(OFS[i], 8'hFF);
            host.rd(OFS[i], d);
            chk(d, MSK[i], "reserved bits written");
        end
        host.wr(8'h47, 8'hFF);
        host.rd(8'h47, d);
        chk(d, 8'h00, "unmapped address");
        $display("register access test done");
    endtask
    task automatic test_warn();
        for (int c = 0; c < 4; c++)
        begin
            host.wr(OFS_OV_WARN, 8'(c));
            host.wr(OFS_UV_WARN, 8'(c));
            drive(1000 + 100 * c, 1000 + 100 * c, 6);
            clr_status();
            drive(tgt, tgt + WMV[c], 6);
            chk(8'(st.overvolt_warning_flag), 8'h00, "ov warn at level");
            drive(tgt, tgt + WMV[c] + 1, 6);
            chk(8'(st.overvolt_warning_flag), 8'h01, "ov warn above");
            drive(tgt, tgt - WMV[c], 6);
            chk(8'(st.undervolt_warning_flag), 8'h00, "uv warn at level");
            drive(tgt, tgt - WMV[c] - 1, 6);
            chk(8'(st.undervolt_warning_flag), 8'h01, "uv warn below");
        end
        drive(tgt, tgt + 500, 8);
        chk(8'(st.overvolt_fault_flag), 8'h00, "ov fault before ramp end");
        drive(tgt, tgt - 400, 300);
        chk(8'(st.undervolt_fault_flag), 8'h00, "uv fault before ramp end");
        chk(8'(off), 8'h00, "off before ramp end");
        $display("warning threshold test done");
    endtask
    task automatic test_uv();
        ss_done <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            host.wr(OFS_UV_FAULT, 8'(c));
            clr_status();
            drive(tgt, tgt - FMV[c], 6);
            chk(8'(st.undervolt_fault_flag), 8'h00, "uv fault at level");
            drive(tgt, tgt - FMV[c] - 1, 6);
            chk(8'(st.undervolt_fault_flag), 8'h01, "uv fault below");
            host.wr(OFS_UV_ACTION, 8'h08 | 8'(c));
            step(DLY[c] - 60);
            chk(8'(off), 8'h00, "off before delay");
            step(70);
            chk(8'(off), 8'h01, "off after delay");
            drive(tgt, tgt, RCYC + 20);
            chk(8'(off), 8'h00, "auto restart");
        end
        host.wr(OFS_UV_FAULT, 8'h00);
        // latch-off at 2 us: two 150-cycle dips would qualify unless recovery clears the timer
        host.wr(OFS_UV_ACTION, 8'h00);
        drive(tgt, tgt - 151, 150);
        drive(tgt, tgt, 10);
        drive(tgt, tgt - 151, 150);
        chk(8'(off), 8'h00, "timer cleared on recovery");
        step(100);
        chk(8'(off), 8'h01, "latched off");
        drive(tgt, tgt, 100);
        chk(8'(off), 8'h01, "latch holds");
        en_tog <= ~en_tog;
        step(10);
        chk(8'(off), 8'h00, "toggle releases latch");
        $display("undervoltage fault test done");
    endtask
    task automatic test_ov();
        for (int r = 0; r < 2; r++)
        begin
            host.wr(OFS_OV_ACTION, r ? 8'h08 : 8'h00);
            clr_status();
            drive(tgt, tgt + 400, 8);
            chk(8'(st.overvolt_fault_flag), 8'h00, "ov fault at level");
            drive(tgt, tgt + 401, 8);
            chk(8'(st.overvolt_fault_flag), 8'h01, "ov fault flag");
            chk(8'(negative_current_limit_mode), 8'h01, "negative current mode");
            chk(8'(off), 8'h01, "off on ov fault");
            drive(tgt, tgt, RCYC + 20);
            chk(8'(off), 8'(r == 0), "ov latch or restart");
            en_tog <= ~en_tog;
            step(10);
            chk(8'(off), 8'h00, "running again");
        end
        $display("overvoltage fault test done");
    endtask
    task automatic test_oc_ot();
        for (int s = 0; s < 16; s++)
        begin
            host.wr(OFS_OC_LIMIT, 8'(s));
            host.wr(OFS_OT_FAULT, 8'(s % 8));
            drive(tgt, tgt, 0);
            valley <= 4'(s);
            temp <= 8'(114 + 5 * (s % 8));
            step(6);
            chk(8'(ocf), 8'h00, "valley at limit");
            chk(8'(otf), 8'h00, "temp below limit");
            valley <= (s < 15) ? 4'(s + 1) : 4'(s);
            temp <= 8'(115 + 5 * (s % 8));
            step(6);
            chk(8'(ocf), 8'(s < 15), "valley above limit");
            chk(8'(otf), 8'h01, "temp at limit");
        end
        $display("current and temperature test done");
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        foreach (nvm[i]) nvm[i] = 8'hF8 + 8'(i);
        step(20);
        rstn <= 1'b1;
        step(3);
        test_regs();
        test_warn();
        test_uv();
        test_ov();
        test_oc_ot();
        print_verdict();
    end
    // the whole run needs about 36k cycles, so 80k means a hang
    initial
    begin
        step(80000);
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
